/* File: pkg/adc_regs_pkg.sv */
`default_nettype none
package adc_regs_pkg;

  // Register pointer codes
  localparam logic [1:0] PTR_RESULT = 2'h0;
  localparam logic [1:0] PTR_CONFIG = 2'h1;
  localparam logic [1:0] PTR_LOW_THRESHOLD = 2'h2;
  localparam logic [1:0] PTR_HIGH_THRESHOLD = 2'h3;

  // Result layout and reset, read fill values
  localparam logic [15:0] RESULT_RESET = 16'h0000;
  localparam logic [3:0] RESULT_PAD = 4'h0;
  localparam logic [15:0] UNMAPPED_WORD = 16'h0000;
  localparam logic [7:0] PAST_END_BYTE = 8'h00;

  // Write byte positions after the address byte
  localparam logic [1:0] WR_IDX_NONE = 2'h0;
  localparam logic [1:0] WR_IDX_MSB = 2'h1;
  localparam logic [1:0] WR_IDX_LSB = 2'h2;
  localparam logic [1:0] WR_IDX_DONE = 2'h3;

  // Field decode limits
  localparam logic [2:0] GAIN_SMALLEST = 3'h5;
  localparam logic [2:0] RATE_FASTEST = 3'h6;
  localparam logic [1:0] AIN_PIN_3 = 2'h3;

  // Configuration word, MSB first
  typedef struct packed {
    logic single_shot_start_status;
    logic [2:0] input_pair_select;
    logic [2:0] gain_range_select;
    logic single_shot_mode;
    logic [2:0] conversion_rate_select;
    logic [4:0] comparator_ctl;
  } config_t;

  localparam config_t CONFIG_RESET = config_t'(16'h8583);

  // One byte written by the serial engine
  typedef struct packed {
    logic valid;
    logic first;
    logic [7:0] data;
  } byte_wr_t;

endpackage
`default_nettype wire

/* File: logic/conversion_sequencer.sv */
`timescale 1ns/10ps
`default_nettype none
module conversion_sequencer (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Requests
  input wire logic start_single_i,
  input wire logic continuous_i,
  // Converter core
  input wire logic conv_done_i,
  output logic conv_start_o,
  output logic busy_o
);
  import adc_regs_pkg::*;

  typedef enum logic {S_IDLE, S_WAIT} seq_state_t;
  seq_state_t state;
  wire go = (state == S_IDLE) && (start_single_i || continuous_i);
  wire finish = (state == S_WAIT) && conv_done_i;

  // Launch one conversion, wait for its end
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      state <= S_IDLE;
      conv_start_o <= 1'b0;
      busy_o <= 1'b0;
    end else begin
      conv_start_o <= go;
      case (state)
        S_IDLE: begin
          if (go) begin
            state <= S_WAIT;
            busy_o <= 1'b1;
          end
        end
        S_WAIT: begin
          if (finish) begin
            state <= S_IDLE;
            busy_o <= 1'b0;
          end
        end
        default: begin
          state <= S_IDLE;
          busy_o <= 1'b0;
        end
      endcase
    end
  end

  // Checks
  chk_single_launch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    (state == S_IDLE) && start_single_i |=> conv_start_o && busy_o)
    else $error("single-shot request did not launch");
  chk_continuous_relaunch: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    finish && continuous_i |=> !busy_o ##1 (conv_start_o || !continuous_i))
    else $error("continuous mode did not relaunch");
  chk_busy_until_done: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    busy_o && !conv_done_i |=> busy_o)
    else $error("busy dropped without conversion end");
  cov_continuous: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    finish && continuous_i ##2 conv_start_o);

endmodule // conversion_sequencer
`default_nettype wire

/* File: logic/adc_register_core.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_register_core (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // Write byte stream from the serial engine
  input wire adc_regs_pkg::byte_wr_t wr_byte_i,
  // Read byte stream to the serial engine
  input wire logic rd_req_i,
  input wire logic rd_first_i,
  output logic [7:0] rd_byte_o,
  output logic rd_valid_o,
  // Converter core
  input wire logic conv_done_i,
  input wire logic [11:0] conv_data_i,
  output logic conv_start_o,
  output logic busy_o,
  // Analog settings
  output logic [1:0] ain_pos_o,
  output logic [1:0] ain_neg_o,
  output logic ain_neg_gnd_o,
  output logic [2:0] full_scale_range_o,
  output logic single_shot_mode_o,
  output logic [2:0] conv_rate_o
);
  import adc_regs_pkg::*;

  logic [1:0] pointer;
  logic [1:0] wr_idx;
  logic [7:0] msb_hold;
  config_t cfg;
  logic [15:0] result;
  logic [15:0] rd_snapshot;
  logic lsb_pending;

  // Write decode
  wire wr_pointer = wr_byte_i.valid && wr_byte_i.first;
  wire wr_data = wr_byte_i.valid && !wr_byte_i.first;
  wire wr_msb = wr_data && (wr_idx == WR_IDX_MSB);
  wire wr_lsb = wr_data && (wr_idx == WR_IDX_LSB);
  wire cfg_commit = wr_lsb && (pointer == PTR_CONFIG);
  wire [15:0] next_cfg_word = {msb_hold, wr_byte_i.data};
  wire powered_down = !busy_o && cfg.single_shot_mode;
  wire start_single = cfg_commit && next_cfg_word[15] && powered_down;

  // Conversion capture
  wire result_load = conv_done_i && busy_o;
  wire [15:0] next_result = {conv_data_i, RESULT_PAD};

  // Read word selection
  wire [15:0] cfg_image = {!busy_o, cfg[14:0]};
  wire [15:0] sel_word = (pointer == PTR_RESULT) ? result :
                         (pointer == PTR_CONFIG) ? cfg_image : UNMAPPED_WORD;

  // Analog setting decode
  wire mux_single = cfg.input_pair_select[2];
  wire [1:0] mux_code = cfg.input_pair_select[1:0];
  wire [1:0] next_ain_pos = mux_single ? mux_code :
                            (mux_code == 2'h0 || mux_code == 2'h1) ? 2'h0 : mux_code - 2'h1;
  wire [1:0] next_ain_neg = mux_single ? 2'h0 :
                            (mux_code == 2'h0) ? 2'h1 : AIN_PIN_3;
  wire [2:0] next_fsr = (cfg.gain_range_select > GAIN_SMALLEST) ?
                        GAIN_SMALLEST : cfg.gain_range_select;
  wire [2:0] next_rate = (cfg.conversion_rate_select > RATE_FASTEST) ?
                         RATE_FASTEST : cfg.conversion_rate_select;

  // Pointer and write byte counter
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      pointer <= PTR_RESULT;
      wr_idx <= WR_IDX_NONE;
      msb_hold <= 8'h00;
    end else if (wr_pointer) begin
      pointer <= wr_byte_i.data[1:0];
      wr_idx <= WR_IDX_MSB;
    end else if (wr_msb) begin
      msb_hold <= wr_byte_i.data;
      wr_idx <= WR_IDX_LSB;
    end else if (wr_lsb) begin
      wr_idx <= WR_IDX_DONE;
    end
  end

  // Configuration register
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      cfg <= CONFIG_RESET;
    end else if (cfg_commit) begin
      cfg <= config_t'({1'b1, next_cfg_word[14:0]});
    end
  end

  // Result register, whole word at once
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      result <= RESULT_RESET;
    end else if (result_load) begin
      result <= next_result;
    end
  end

  // Read path, word frozen at the first byte
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      rd_snapshot <= 16'h0000;
      lsb_pending <= 1'b0;
      rd_byte_o <= 8'h00;
      rd_valid_o <= 1'b0;
    end else begin
      rd_valid_o <= rd_req_i;
      if (rd_req_i && rd_first_i) begin
        rd_snapshot <= sel_word;
        rd_byte_o <= sel_word[15:8];
        lsb_pending <= 1'b1;
      end else if (rd_req_i) begin
        rd_byte_o <= lsb_pending ? rd_snapshot[7:0] : PAST_END_BYTE;
        lsb_pending <= 1'b0;
      end
    end
  end

  // Registered analog settings
  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      ain_pos_o <= 2'h0;
      ain_neg_o <= 2'h1;
      ain_neg_gnd_o <= 1'b0;
      full_scale_range_o <= CONFIG_RESET.gain_range_select;
      single_shot_mode_o <= CONFIG_RESET.single_shot_mode;
      conv_rate_o <= CONFIG_RESET.conversion_rate_select;
    end else begin
      ain_pos_o <= next_ain_pos;
      ain_neg_o <= next_ain_neg;
      ain_neg_gnd_o <= mux_single;
      full_scale_range_o <= next_fsr;
      single_shot_mode_o <= cfg.single_shot_mode;
      conv_rate_o <= next_rate;
    end
  end

  // Conversion sequencing
  conversion_sequencer u_sequencer (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .start_single_i(start_single),
    .continuous_i(!cfg.single_shot_mode),
    .conv_done_i(conv_done_i),
    .conv_start_o(conv_start_o),
    .busy_o(busy_o)
  );

  // Checks
  chk_result_pad_zero: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result[3:0] == 4'h0)
    else $error("result low nibble not zero");
  chk_result_capture: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    result_load |=> result[15:4] == $past(conv_data_i))
    else $error("result not captured");
  chk_result_stable: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !result_load |=> $stable(result))
    else $error("result changed without conversion");
  chk_pointer_kept: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    !wr_pointer |=> $stable(pointer))
    else $error("pointer changed without write");
  chk_config_reset: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    $rose(rst_n_i) |-> cfg[14:0] == CONFIG_RESET[14:0] && !busy_o)
    else $error("configuration reset value wrong");
  chk_status_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i && rd_first_i && pointer == PTR_CONFIG |=> rd_byte_o[7] == !$past(busy_o))
    else $error("status bit wrong on read");
  chk_result_select: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i && rd_first_i && pointer == PTR_RESULT |=> rd_byte_o == $past(result[15:8]))
    else $error("pointer zero did not select result");
  chk_start_ignored: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_commit && busy_o |=> !conv_start_o)
    else $error("start accepted while converting");
  chk_config_write: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_commit |=> cfg[14:0] == $past(next_cfg_word[14:0]))
    else $error("configuration write lost");
  chk_pair_decode: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    mux_single |=> ain_neg_gnd_o && ain_pos_o == $past(mux_code))
    else $error("single-ended input decode wrong");
  chk_gain_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.gain_range_select > 3'h5 |=> full_scale_range_o == 3'h5)
    else $error("gain codes above 101 not clamped");
  chk_rate_clamp: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg.conversion_rate_select == 3'h7 |=> conv_rate_o == 3'h6)
    else $error("rate code 111 not fastest");
  chk_atomic_read: assert property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i && rd_first_i ##1 rd_req_i && !rd_first_i
    |=> rd_byte_o == $past(rd_snapshot[7:0], 1))
    else $error("low byte not from frozen word");
  cov_single_shot: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    start_single ##1 conv_start_o);
  cov_config_read: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    rd_req_i && rd_first_i && pointer == PTR_CONFIG ##1 rd_req_i && !rd_first_i);
  cov_busy_write: cover property (@(posedge clk_i) disable iff (!rst_n_i)
    cfg_commit && busy_o);

endmodule // adc_register_core
`default_nettype wire

/* File: testbench/i2c_master_model.sv */
`timescale 1ns/10ps
`default_nettype none
module i2c_master_model (
  // Clock
  input wire logic clk_i,
  // Byte streams to and from the register core
  output var adc_regs_pkg::byte_wr_t wr_byte_o,
  output logic rd_req_o,
  output logic rd_first_o,
  input wire logic [7:0] rd_byte_i,
  input wire logic rd_valid_i
);
  import adc_regs_pkg::*;

  // Idle at time zero
  initial begin
    wr_byte_o = '{valid: 1'b0, first: 1'b0, data: 8'h00};
    rd_req_o = 1'b0;
    rd_first_o = 1'b0;
  end

  // One byte per cycle on the write stream
  task automatic put_byte(input logic first, input logic [7:0] data);
    @(posedge clk_i);
    wr_byte_o <= '{valid: 1'b1, first: first, data: data};
  endtask

  // Release; stale data is inverted so it cannot pass for valid
  task automatic idle_wr(input logic [7:0] last);
    @(posedge clk_i);
    wr_byte_o <= '{valid: 1'b0, first: 1'b0, data: ~last};
  endtask

  // Pointer-only write
  task automatic wr_ptr(input logic [1:0] ptr);
    put_byte(1'b1, {6'h00, ptr});
    idle_wr({6'h00, ptr});
  endtask

  // Pointer byte then high byte then low byte
  task automatic wr_reg(input logic [1:0] ptr, input logic [15:0] word);
    put_byte(1'b1, {6'h00, ptr});
    put_byte(1'b0, word[15:8]);
    put_byte(1'b0, word[7:0]);
    idle_wr(word[7:0]);
  endtask

  // Two-byte read; a missing valid poisons the byte
  task automatic rd_reg(output logic [15:0] word);
    @(posedge clk_i);
    rd_req_o <= 1'b1;
    rd_first_o <= 1'b1;
    @(posedge clk_i);
    rd_first_o <= 1'b0;
    #1;
    word[15:8] = (rd_valid_i === 1'b1) ? rd_byte_i : 8'hxx;
    @(posedge clk_i);
    rd_req_o <= 1'b0;
    #1;
    word[7:0] = (rd_valid_i === 1'b1) ? rd_byte_i : 8'hxx;
  endtask
endmodule // i2c_master_model
`default_nettype wire

/* File: testbench/adc_pointer_conversion_config_regs_bench.sv */
`timescale 1ns/10ps
`default_nettype none
module adc_pointer_conversion_config_regs_bench;
  import adc_regs_pkg::*;

  // Configuration word and the settings it should give
  typedef struct packed {
    logic [15:0] word;
    logic [1:0] pos;
    logic [1:0] neg;
    logic gnd;
    logic [2:0] full_scale_range;
    logic [2:0] rate;
  } row_t;

  logic clk_i, rst_n_i, rd_req, rd_first, rd_valid, conv_done, conv_start, busy, ain_gnd, mode;
  logic [7:0] rd_byte;
  logic [11:0] conv_data;
  logic [1:0] ain_pos, ain_neg;
  logic [2:0] full_scale_range, rate;
  logic [15:0] w;
  byte_wr_t wr_byte;
  int error_cnt = 0;
  int checks = 0;
  int starts = 0;
  int cycles = 0;
  row_t rows [8] = '{'{16'h0103, 2'h0, 2'h1, 1'b0, 3'h0, 3'h0}, '{16'h1323, 2'h0, 2'h3, 1'b0, 3'h1, 3'h1},
    '{16'h2543, 2'h1, 2'h3, 1'b0, 3'h2, 3'h2}, '{16'h3763, 2'h2, 2'h3, 1'b0, 3'h3, 3'h3},
    '{16'h4983, 2'h0, 2'h0, 1'b1, 3'h4, 3'h4}, '{16'h5ba3, 2'h1, 2'h0, 1'b1, 3'h5, 3'h5},
    '{16'h6dc3, 2'h2, 2'h0, 1'b1, 3'h5, 3'h6}, '{16'h7fe3, 2'h3, 2'h0, 1'b1, 3'h5, 3'h6}};

  adc_register_core uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .wr_byte_i(wr_byte), .rd_req_i(rd_req),
    .rd_first_i(rd_first), .rd_byte_o(rd_byte), .rd_valid_o(rd_valid), .conv_done_i(conv_done),
    .conv_data_i(conv_data), .conv_start_o(conv_start), .busy_o(busy), .ain_pos_o(ain_pos),
    .ain_neg_o(ain_neg), .ain_neg_gnd_o(ain_gnd), .full_scale_range_o(full_scale_range), .single_shot_mode_o(mode),
    .conv_rate_o(rate));

  i2c_master_model master (.clk_i(clk_i), .wr_byte_o(wr_byte), .rd_req_o(rd_req), .rd_first_o(rd_first),
    .rd_byte_i(rd_byte), .rd_valid_i(rd_valid));

  // Verdict and end of run
  task automatic end_sim;
    if (error_cnt == 0 && checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // Compare and report
  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Bounded wait for a start pulse
  task automatic wait_start;
    int n;
    #1;
    n = 0;
    while (conv_start !== 1'b1 && n < 20) begin
      @(posedge clk_i);
      #1;
      n++;
    end
    check({14'h0000, conv_start, busy}, 16'h0003);
  endtask

  // Converter core finishing with a result
  task automatic finish_conv(input logic [11:0] d);
    @(posedge clk_i);
    conv_done <= 1'b1;
    conv_data <= d;
    @(posedge clk_i);
    conv_done <= 1'b0;
    conv_data <= ~d;
  endtask

  // Clock
  initial begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end

  // Start counter and hang guard
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (conv_start === 1'b1) begin
      starts <= starts + 1;
    end
    if (cycles == 5000) begin
      error_cnt++;
      end_sim();
    end
  end

  // Main sequence
  initial begin
    rst_n_i = 1'b0;
    conv_done = 1'b0;
    conv_data = 12'h000;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    check({4'h0, ain_pos, ain_neg, ain_gnd, full_scale_range, mode, rate}, 16'h012c);
    master.rd_reg(w);
    check(w, RESULT_RESET);
    master.wr_ptr(PTR_CONFIG);
    master.rd_reg(w);
    check(w, 16'h8583);
    for (int i = 0; i < 8; i++) begin
      master.wr_reg(PTR_CONFIG, rows[i].word);
      master.rd_reg(w);
      check(w, rows[i].word | 16'h8000);
      check({4'h0, ain_pos, rows[i].gnd ? 2'h0 : ain_neg, ain_gnd, full_scale_range, mode, rate},
        {4'h0, rows[i].pos, rows[i].neg, rows[i].gnd, rows[i].full_scale_range, 1'b1, rows[i].rate});
    end
    check(starts[15:0], 16'h0000);
    master.wr_reg(PTR_CONFIG, 16'h8583);
    wait_start();
    master.rd_reg(w);
    check(w, 16'h0583);
    master.wr_reg(PTR_CONFIG, 16'h8583);
    repeat (3) @(posedge clk_i);
    check(starts[15:0], 16'h0001);
    finish_conv(12'h9ab);
    master.wr_reg(PTR_CONFIG, 16'h8583);
    wait_start();
    master.wr_ptr(PTR_RESULT);
    fork
      master.rd_reg(w);
      begin
        @(posedge clk_i);
        finish_conv(12'h123);
      end
    join
    check(w, 16'h9ab0);
    master.rd_reg(w);
    check(w, 16'h1230);
    master.wr_reg(PTR_CONFIG, 16'h0483);
    wait_start();
    check({15'h0000, mode}, 16'h0000);
    finish_conv(12'h7ff);
    wait_start();
    master.wr_reg(PTR_CONFIG, 16'h0583);
    finish_conv(12'h000);
    repeat (5) @(posedge clk_i);
    check({starts[14:0], busy}, 16'h0008);
    for (int p = 2; p < 4; p++) begin
      master.wr_reg(p[1:0], 16'h1234);
      master.rd_reg(w);
      check(w, UNMAPPED_WORD);
    end
    end_sim();
  end
endmodule // adc_pointer_conversion_config_regs_bench
`default_nettype wire
